// ### logic/video_regs_pkg.sv
// Shared constants, types and register map of the video decoder control/status bank
// Summary of operation
// - Signed 8-bit stop offset moves vertical blank end, 127 late to 128 early.
// - Setting colour reset sends a phase reset flag on the next genlock line.
// - After that line, zero the oscillator phase, then clear colour reset.
// - Comb field: 00 auto, 10 comb on, 11 bypassed; 01 reserved.
// - Colour gain field: 00 enabled, 10 disabled, 11 frozen; 01 reserved.
// - Input select bit 0: luma path from first converter, or second when set.
// - Input select bit 1: chroma path from first converter, or second when set.
// - Input select bit 2: internal converters when clear, external; resets set.
// - Identification register returns the firmware revision number.
// - Status one: source type bit 0, horizontal/vertical/subcarrier lock bits 1-3.
// - Lost-lock bit sticky since last status one read; cleared by that read.
// - Field rate bit reads 0 for 60 Hz, 1 for 50 Hz.
// - Status one bit 6 line alternating, bit 7 peak white detected.
// - Status two bit 3 gain and clamp lock, bit 4 odd field.
// - Status two bit 5 PAL switch of first odd line: 0 is 135, 1 is 225.
// - Status three presents current colour gain code, 0.831 percent per step.
// - Status four holds oscillator phase at hsync fall of first odd line.
// - Blank end measured from per-standard end lines, e.g. 21 and 284.5.
package video_regs_pkg;

   // ----------------------------------------
   // Register subaddresses
   // ----------------------------------------
   localparam logic [7:0] ADDR_VBLANK_STOP = 8'h19;
   localparam logic [7:0] ADDR_CHROMA_CTRL = 8'h1a;
   localparam logic [7:0] ADDR_INPUT_SEL = 8'h20;
   localparam logic [7:0] ADDR_REVISION = 8'h80;
   localparam logic [7:0] ADDR_STATUS_ONE = 8'h81;
   localparam logic [7:0] ADDR_STATUS_TWO = 8'h82;
   localparam logic [7:0] ADDR_GAIN = 8'h83;
   localparam logic [7:0] ADDR_SC_PHASE = 8'h84;

   // ----------------------------------------
   // Reset values and fields
   // ----------------------------------------
   localparam logic [7:0] RST_VBLANK_STOP = 8'h00;
   localparam logic [1:0] RST_COMB = 2'h0;
   localparam logic [1:0] RST_GAIN_MODE = 2'h0;
   localparam logic [2:0] RST_INPUT_SEL = 3'h4;
   localparam logic [1:0] CODE_RESERVED = 2'h1;
   localparam int CHROMA_GAIN_LSB = 0;
   localparam int CHROMA_COMB_LSB = 2;
   localparam int CHROMA_RESET_BIT = 4;
   localparam int SEL_LUMA_BIT = 0;
   localparam int SEL_CHROMA_BIT = 1;
   localparam int SEL_EXT_BIT = 2;
   // Arbitrary host port address and revision code
   localparam logic [6:0] DEF_DEV_ADDR = 7'h2e;
   localparam logic [7:0] DEF_REVISION = 8'h01;

   // ----------------------------------------
   // Frame geometry in half lines from line 1
   // ----------------------------------------
   localparam logic [10:0] HL_FRAME_525 = 11'h41a;
   localparam logic [10:0] HL_FRAME_625 = 11'h4e2;
   localparam logic [10:0] HL_END_525_ODD = 11'h028;
   localparam logic [10:0] HL_END_525_EVEN = 11'h237;
   localparam logic [10:0] HL_END_625_ODD = 11'h02d;
   localparam logic [10:0] HL_END_625_EVEN = 11'h29c;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 4;
   localparam int SPIKE_TIME_NS = 50;
   localparam int SPIKE_CYCLES = (SPIKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [1:0] {STD_NTSC, STD_PAL, STD_MPAL, STD_NPAL} video_std_t;

   typedef struct packed {
      logic source_tape;
      logic hsync_lock;
      logic vsync_lock;
      logic subcarrier_lock;
      logic field_50hz;
      logic line_alternating;
      logic peak_white;
      logic gain_clamp_lock;
      logic odd_field;
      logic pal_switch;
      logic [7:0] agc_gain;
      logic [7:0] osc_phase;
   } video_status_t;

   typedef struct packed {
      logic [1:0] comb_mode;
      logic [1:0] auto_colour_gain_mode;
      logic luma_second_converter;
      logic chroma_second_converter;
      logic external_converter;
   } video_ctrl_t;

endpackage

// ### logic/pin_filter.sv
// Spike filter for one sampled pin, with edge pulses
`timescale 1ns/10ps
module pin_filter #(
   parameter int STABLE_CYCLES = 13
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic pin_i,
   output logic level_o,
   output logic rise_o,
   output logic fall_o
);

   localparam int CW = $clog2(STABLE_CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(STABLE_CYCLES - 1);

   logic [CW-1:0] cnt_ff;

   // Level changes only after the pin has held its new value long enough
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_ff <= '0;
         level_o <= 1'b1;
         rise_o <= 1'b0;
         fall_o <= 1'b0;
      end else begin
         rise_o <= 1'b0;
         fall_o <= 1'b0;
         if (pin_i == level_o) begin
            cnt_ff <= '0;
         end else if (cnt_ff == LAST) begin
            cnt_ff <= '0;
            level_o <= pin_i;
            rise_o <= pin_i;
            fall_o <= ~pin_i;
         end else begin
            cnt_ff <= cnt_ff + 1'b1;
         end
      end
   end

endmodule

// ### logic/video_ctrl_regs.sv
// Control and status register bank of the video decoder behind its serial host port
`timescale 1ns/10ps
module video_ctrl_regs #(
   parameter logic [6:0] DEV_ADDR = video_regs_pkg::DEF_DEV_ADDR,
   parameter logic [7:0] REVISION = video_regs_pkg::DEF_REVISION,
   parameter int FILTER_CYCLES = video_regs_pkg::SPIKE_CYCLES
) (
   // Clock and reset
   input wire logic MCLK_I,
   input wire logic NRST_I,
   // Host port, open drain data
   input wire logic SCL_I,
   input wire logic SDA_I,
   output logic SDA_O,
   output logic SDA_OE_O,
   // Video timing
   input wire logic HALF_LINE_I,
   input wire logic FRAME_START_I,
   input wire logic LINE_START_I,
   input wire logic PHASE_SAMPLE_I,
   input wire video_regs_pkg::video_std_t STD_I,
   input wire video_regs_pkg::video_status_t STATUS_I,
   // Controls to the datapath
   output video_regs_pkg::video_ctrl_t CTRL_O,
   output logic VBLANK_END_O,
   output logic GENLOCK_PHASE_RESET_O,
   output logic OSC_PHASE_ZERO_O
);

   typedef enum {
      ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_SUB, ST_SUB_ACK, ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK
   } host_state_t;

   // ----------------------------------------
   // Pin filtering
   // ----------------------------------------
   logic scl_level, scl_rise, scl_fall;
   logic sda_level, sda_rise, sda_fall;

   pin_filter #(.STABLE_CYCLES(FILTER_CYCLES)) scl_filt (
      .clk_i(MCLK_I),
      .rst_n_i(NRST_I),
      .pin_i(SCL_I),
      .level_o(scl_level),
      .rise_o(scl_rise),
      .fall_o(scl_fall)
   );

   pin_filter #(.STABLE_CYCLES(FILTER_CYCLES)) sda_filt (
      .clk_i(MCLK_I),
      .rst_n_i(NRST_I),
      .pin_i(SDA_I),
      .level_o(sda_level),
      .rise_o(sda_rise),
      .fall_o(sda_fall)
   );

   logic bus_start, bus_stop;
   assign bus_start = sda_fall & scl_level;
   assign bus_stop = sda_rise & scl_level;

   // ----------------------------------------
   // Host port engine
   // ----------------------------------------
   host_state_t state_ff;
   logic [3:0] bit_cnt_ff;
   logic [7:0] shift_ff;
   logic [7:0] tx_ff;
   logic [7:0] sub_ff;
   logic rw_ff;
   logic wr_ff;
   logic [7:0] wr_addr_ff;
   logic [7:0] wr_data_ff;
   logic rd_load;
   logic [7:0] rd_data;

   logic [7:0] vblank_stop_ff;
   logic [1:0] comb_ff;
   logic [1:0] gain_mode_ff;
   logic colour_reset_ff;
   logic [2:0] input_sel_ff;
   logic lost_lock_ff;
   logic pal_switch_ff;
   logic [7:0] sc_phase_ff;

   // Loading a read byte happens on the SCL fall that opens it
   always_comb begin
      rd_load = 1'b0;
      if (scl_fall) begin
         if (state_ff == ST_ADDR_ACK && rw_ff) begin
            rd_load = 1'b1;
         end else if (state_ff == ST_RDATA_ACK && !shift_ff[0]) begin
            rd_load = 1'b1;
         end
      end
   end

   always_comb begin
      case (sub_ff)
         video_regs_pkg::ADDR_VBLANK_STOP: rd_data = vblank_stop_ff;
         video_regs_pkg::ADDR_CHROMA_CTRL: rd_data = {3'h0, colour_reset_ff, comb_ff, gain_mode_ff};
         video_regs_pkg::ADDR_INPUT_SEL: rd_data = {5'h00, input_sel_ff};
         video_regs_pkg::ADDR_REVISION: rd_data = REVISION;
         video_regs_pkg::ADDR_STATUS_ONE: rd_data = {STATUS_I.peak_white, STATUS_I.line_alternating,
            STATUS_I.field_50hz, lost_lock_ff, STATUS_I.subcarrier_lock,
            STATUS_I.vsync_lock, STATUS_I.hsync_lock, STATUS_I.source_tape};
         video_regs_pkg::ADDR_STATUS_TWO: rd_data = {2'h0, pal_switch_ff, STATUS_I.odd_field,
            STATUS_I.gain_clamp_lock, 3'h0};
         video_regs_pkg::ADDR_GAIN: rd_data = STATUS_I.agc_gain;
         video_regs_pkg::ADDR_SC_PHASE: rd_data = sc_phase_ff;
         default: rd_data = 8'h00;
      endcase
   end

   always_ff @(posedge MCLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         state_ff <= ST_IDLE;
         bit_cnt_ff <= 4'h0;
         shift_ff <= 8'h00;
         tx_ff <= 8'h00;
         sub_ff <= 8'h00;
         rw_ff <= 1'b0;
         SDA_OE_O <= 1'b0;
         wr_ff <= 1'b0;
         wr_addr_ff <= 8'h00;
         wr_data_ff <= 8'h00;
      end else begin
         wr_ff <= 1'b0;
         if (bus_stop) begin
            state_ff <= ST_IDLE;
            SDA_OE_O <= 1'b0;
         end else if (bus_start) begin
            state_ff <= ST_ADDR;
            bit_cnt_ff <= 4'h0;
            SDA_OE_O <= 1'b0;
         end else if (scl_rise) begin
            case (state_ff)
               ST_ADDR, ST_SUB, ST_WDATA: begin
                  shift_ff <= {shift_ff[6:0], sda_level};
                  bit_cnt_ff <= bit_cnt_ff + 4'h1;
               end
               ST_RDATA: bit_cnt_ff <= bit_cnt_ff + 4'h1;
               ST_RDATA_ACK: shift_ff <= {7'h00, sda_level};
               default: ;
            endcase
         end else if (scl_fall) begin
            case (state_ff)
               ST_ADDR: begin
                  if (bit_cnt_ff == 4'h8) begin
                     bit_cnt_ff <= 4'h0;
                     if (shift_ff[7:1] == DEV_ADDR) begin
                        rw_ff <= shift_ff[0];
                        SDA_OE_O <= 1'b1;
                        state_ff <= ST_ADDR_ACK;
                     end else begin
                        state_ff <= ST_IDLE;
                     end
                  end
               end
               ST_ADDR_ACK, ST_RDATA_ACK: begin
                  bit_cnt_ff <= 4'h0;
                  if (rd_load) begin
                     SDA_OE_O <= ~rd_data[7];
                     tx_ff <= {rd_data[6:0], 1'b0};
                     sub_ff <= sub_ff + 8'h01;
                     state_ff <= ST_RDATA;
                  end else begin
                     SDA_OE_O <= 1'b0;
                     state_ff <= (state_ff == ST_ADDR_ACK) ? ST_SUB : ST_IDLE;
                  end
               end
               ST_SUB: begin
                  if (bit_cnt_ff == 4'h8) begin
                     bit_cnt_ff <= 4'h0;
                     sub_ff <= shift_ff;
                     SDA_OE_O <= 1'b1;
                     state_ff <= ST_SUB_ACK;
                  end
               end
               ST_SUB_ACK, ST_WDATA_ACK: begin
                  SDA_OE_O <= 1'b0;
                  state_ff <= ST_WDATA;
               end
               ST_WDATA: begin
                  if (bit_cnt_ff == 4'h8) begin
                     bit_cnt_ff <= 4'h0;
                     wr_ff <= 1'b1;
                     wr_addr_ff <= sub_ff;
                     wr_data_ff <= shift_ff;
                     sub_ff <= sub_ff + 8'h01;
                     SDA_OE_O <= 1'b1;
                     state_ff <= ST_WDATA_ACK;
                  end
               end
               ST_RDATA: begin
                  if (bit_cnt_ff == 4'h8) begin
                     SDA_OE_O <= 1'b0;
                     state_ff <= ST_RDATA_ACK;
                  end else begin
                     SDA_OE_O <= ~tx_ff[7];
                     tx_ff <= {tx_ff[6:0], 1'b0};
                  end
               end
               default: ;
            endcase
         end
      end
   end

   // Open drain: the pad value is always low, only the enable moves
   always_ff @(posedge MCLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         SDA_O <= 1'b0;
      end else begin
         SDA_O <= 1'b0;
      end
   end

   // ----------------------------------------
   // Writable registers
   // ----------------------------------------
   logic wr_vblank, wr_chroma, wr_input;
   assign wr_vblank = wr_ff && wr_addr_ff == video_regs_pkg::ADDR_VBLANK_STOP;
   assign wr_chroma = wr_ff && wr_addr_ff == video_regs_pkg::ADDR_CHROMA_CTRL;
   assign wr_input = wr_ff && wr_addr_ff == video_regs_pkg::ADDR_INPUT_SEL;

   logic [1:0] wr_comb, wr_gain;
   assign wr_comb = wr_data_ff[video_regs_pkg::CHROMA_COMB_LSB +: 2];
   assign wr_gain = wr_data_ff[video_regs_pkg::CHROMA_GAIN_LSB +: 2];

   // Status and identification addresses have no write path at all
   always_ff @(posedge MCLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         vblank_stop_ff <= video_regs_pkg::RST_VBLANK_STOP;
         comb_ff <= video_regs_pkg::RST_COMB;
         gain_mode_ff <= video_regs_pkg::RST_GAIN_MODE;
         input_sel_ff <= video_regs_pkg::RST_INPUT_SEL;
      end else begin
         if (wr_vblank) begin
            vblank_stop_ff <= wr_data_ff;
         end
         // Reserved codes would leave the datapath undefined, so they are dropped
         if (wr_chroma && wr_comb != video_regs_pkg::CODE_RESERVED) begin
            comb_ff <= wr_comb;
         end
         if (wr_chroma && wr_gain != video_regs_pkg::CODE_RESERVED) begin
            gain_mode_ff <= wr_gain;
         end
         if (wr_input) begin
            input_sel_ff <= wr_data_ff[2:0];
         end
      end
   end

   always_ff @(posedge MCLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         CTRL_O <= '0;
      end else begin
         CTRL_O.comb_mode <= comb_ff;
         CTRL_O.auto_colour_gain_mode <= gain_mode_ff;
         CTRL_O.luma_second_converter <= input_sel_ff[video_regs_pkg::SEL_LUMA_BIT];
         CTRL_O.chroma_second_converter <= input_sel_ff[video_regs_pkg::SEL_CHROMA_BIT];
         CTRL_O.external_converter <= input_sel_ff[video_regs_pkg::SEL_EXT_BIT];
      end
   end

   // ----------------------------------------
   // Colour reset and genlock flag
   // ----------------------------------------
   logic wr_colour_set, wr_colour_clr, flag_done;
   assign wr_colour_set = wr_chroma & wr_data_ff[video_regs_pkg::CHROMA_RESET_BIT];
   assign wr_colour_clr = wr_chroma & ~wr_data_ff[video_regs_pkg::CHROMA_RESET_BIT];
   assign flag_done = LINE_START_I & GENLOCK_PHASE_RESET_O;

   // Flag rides one whole line; its end zeroes the oscillator
   always_ff @(posedge MCLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         GENLOCK_PHASE_RESET_O <= 1'b0;
         OSC_PHASE_ZERO_O <= 1'b0;
      end else begin
         OSC_PHASE_ZERO_O <= flag_done;
         if (flag_done) begin
            GENLOCK_PHASE_RESET_O <= 1'b0;
         end else if (LINE_START_I && colour_reset_ff) begin
            GENLOCK_PHASE_RESET_O <= 1'b1;
         end
      end
   end

   // A fresh host set in the clearing cycle survives
   always_ff @(posedge MCLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         colour_reset_ff <= 1'b0;
      end else if (wr_colour_set) begin
         colour_reset_ff <= 1'b1;
      end else if (wr_colour_clr || OSC_PHASE_ZERO_O) begin
         colour_reset_ff <= 1'b0;
      end
   end

   // ----------------------------------------
   // Sticky lost lock and sampled status
   // ----------------------------------------
   logic locked_prev_ff, lock_lost;
   assign lock_lost = locked_prev_ff & ~(STATUS_I.hsync_lock & STATUS_I.vsync_lock);

   always_ff @(posedge MCLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         locked_prev_ff <= 1'b0;
         lost_lock_ff <= 1'b0;
      end else begin
         locked_prev_ff <= STATUS_I.hsync_lock & STATUS_I.vsync_lock;
         if (lock_lost) begin
            lost_lock_ff <= 1'b1;
         end else if (rd_load && sub_ff == video_regs_pkg::ADDR_STATUS_ONE) begin
            lost_lock_ff <= 1'b0;
         end
      end
   end

   // Phase sampled at the hsync fall of the first odd line
   always_ff @(posedge MCLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         sc_phase_ff <= 8'h00;
         pal_switch_ff <= 1'b0;
      end else if (PHASE_SAMPLE_I) begin
         sc_phase_ff <= OSC_PHASE_ZERO_O ? 8'h00 : STATUS_I.osc_phase;
         pal_switch_ff <= STATUS_I.pal_switch;
      end
   end

   // ----------------------------------------
   // Vertical blank end placement
   // ----------------------------------------
   logic [10:0] hl_cnt_ff, frame_hl, end_odd, end_even;
   logic [10:0] tgt_odd, tgt_even, hl_next;

   always_comb begin
      case (STD_I)
         video_regs_pkg::STD_PAL, video_regs_pkg::STD_NPAL: begin
            frame_hl = video_regs_pkg::HL_FRAME_625;
            end_odd = video_regs_pkg::HL_END_625_ODD;
            end_even = video_regs_pkg::HL_END_625_EVEN;
         end
         default: begin
            frame_hl = video_regs_pkg::HL_FRAME_525;
            end_odd = video_regs_pkg::HL_END_525_ODD;
            end_even = video_regs_pkg::HL_END_525_EVEN;
         end
      endcase
   end

   function automatic logic [10:0] shift_end(input logic [10:0] base, input logic [7:0] off,
                                             input logic [10:0] frame);
      logic signed [12:0] t;
      t = $signed({2'b00, base}) + $signed({{4{off[7]}}, off, 1'b0});
      if (t < 0) begin
         t = t + $signed({2'b00, frame});
      end else if (t >= $signed({2'b00, frame})) begin
         t = t - $signed({2'b00, frame});
      end
      return t[10:0];
   endfunction

   // Offset counts whole lines, two half lines each, positive is later
   assign tgt_odd = shift_end(end_odd, vblank_stop_ff, frame_hl);
   assign tgt_even = shift_end(end_even, vblank_stop_ff, frame_hl);
   assign hl_next = (hl_cnt_ff + 11'h001 >= frame_hl) ? 11'h000 : hl_cnt_ff + 11'h001;

   always_ff @(posedge MCLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         hl_cnt_ff <= 11'h000;
         VBLANK_END_O <= 1'b0;
      end else begin
         VBLANK_END_O <= 1'b0;
         if (FRAME_START_I) begin
            hl_cnt_ff <= 11'h000;
            VBLANK_END_O <= (tgt_odd == 11'h000) || (tgt_even == 11'h000);
         end else if (HALF_LINE_I) begin
            hl_cnt_ff <= hl_next;
            VBLANK_END_O <= (hl_next == tgt_odd) || (hl_next == tgt_even);
         end
      end
   end

endmodule

// ### testbench/video_ctrl_regs_chk_props.sv
// Checker for the line, blank and control outputs of the register bank
`timescale 1ns/10ps
module video_ctrl_regs_chk (
   // Clock and timing
   input wire logic MCLK_I,
   input wire logic NRST_I,
   input wire logic HALF_LINE_I,
   input wire logic FRAME_START_I,
   input wire logic LINE_START_I,
   // Outputs
   input wire video_regs_pkg::video_ctrl_t CTRL_O,
   input wire logic VBLANK_END_O,
   input wire logic GENLOCK_PHASE_RESET_O,
   input wire logic OSC_PHASE_ZERO_O
);
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (!NRST_I);
   // ------------------------------
   // Properties
   // ------------------------------
   property p_vb_one; VBLANK_END_O |=> !VBLANK_END_O; endproperty
   a_vb_one: assert property (p_vb_one) else $error("blank end too long");
   property p_vb_src; VBLANK_END_O |-> $past(HALF_LINE_I) || $past(FRAME_START_I); endproperty
   a_vb_src: assert property (p_vb_src) else $error("blank end without count step");
   property p_gl_line; !$past(LINE_START_I) |-> $stable(GENLOCK_PHASE_RESET_O); endproperty
   a_gl_line: assert property (p_gl_line) else $error("genlock flag off line boundary");
   property p_zero_src; OSC_PHASE_ZERO_O |-> $past(LINE_START_I) && $past(GENLOCK_PHASE_RESET_O); endproperty
   a_zero_src: assert property (p_zero_src) else $error("zeroing without sent flag");
   property p_zero_drop; $fell(GENLOCK_PHASE_RESET_O) |-> OSC_PHASE_ZERO_O; endproperty
   a_zero_drop: assert property (p_zero_drop) else $error("flag sent but no zeroing");
   property p_ext_rst; $rose(NRST_I) |-> ##[1:2] CTRL_O.external_converter; endproperty
   a_ext_rst: assert property (p_ext_rst) else $error("external select not set by reset");
   property p_comb_ok; CTRL_O.comb_mode != video_regs_pkg::CODE_RESERVED; endproperty
   a_comb_ok: assert property (p_comb_ok) else $error("reserved comb code");
   property p_gain_ok; CTRL_O.auto_colour_gain_mode != video_regs_pkg::CODE_RESERVED; endproperty
   a_gain_ok: assert property (p_gain_ok) else $error("reserved gain code");
endmodule
bind video_ctrl_regs video_ctrl_regs_chk u_video_ctrl_regs_chk (.MCLK_I(MCLK_I), .NRST_I(NRST_I),
   .HALF_LINE_I(HALF_LINE_I), .FRAME_START_I(FRAME_START_I), .LINE_START_I(LINE_START_I), .CTRL_O(CTRL_O),
   .VBLANK_END_O(VBLANK_END_O), .GENLOCK_PHASE_RESET_O(GENLOCK_PHASE_RESET_O), .OSC_PHASE_ZERO_O(OSC_PHASE_ZERO_O));

// ### testbench/host_port_model.sv
// Behavioural host controller on the serial register port
`timescale 1ns/10ps
module host_port_model #(
   parameter logic [6:0] DEV_ADDR = video_regs_pkg::DEF_DEV_ADDR,
   parameter int HALF = 10
) (
   // Clock and bus
   input wire logic clk_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_o
);
   int nack_cnt = 0;
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   // ------------------------------
   // Bus phases
   // ------------------------------
   task automatic hw();
      repeat (HALF) @(posedge clk_i);
   endtask
   // Data only moves while the clock is low
   task automatic xbit(input logic b, output logic r);
      sda_o <= b;
      hw();
      scl_o <= 1'b1;
      hw();
      r = sda_i;
      scl_o <= 1'b0;
      hw();
   endtask
   task automatic start_c();
      sda_o <= 1'b1;
      hw();
      scl_o <= 1'b1;
      hw();
      sda_o <= 1'b0;
      hw();
      scl_o <= 1'b0;
      hw();
   endtask
   task automatic xbyte(input logic [7:0] d, input logic ak, output logic [8:0] q);
      logic [8:0] w;
      w = {d, ak};
      for (int i = 8; i >= 0; i--) xbit(w[i], q[i]);
   endtask
   task automatic sendb(input logic [7:0] d);
      logic [8:0] q;
      xbyte(d, 1'b1, q);
      nack_cnt += int'(q[0]);
   endtask
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      start_c();
      sendb({DEV_ADDR, 1'b0});
      sendb(a);
      sendb(d);
      sda_o <= 1'b0;
      hw();
      scl_o <= 1'b1;
      hw();
      sda_o <= 1'b1;
      hw();
   endtask
   // Single byte read ends with a refusal so the device lets go
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      logic [8:0] q;
      start_c();
      sendb({DEV_ADDR, 1'b0});
      sendb(a);
      start_c();
      sendb({DEV_ADDR, 1'b1});
      xbyte(8'hff, 1'b1, q);
      d = q[8:1];
      sda_o <= 1'b0;
      hw();
      scl_o <= 1'b1;
      hw();
      sda_o <= 1'b1;
      hw();
   endtask
endmodule

// ### testbench/video_ctrl_regs_test.sv
// Self-checking bench for the video decoder register bank
`timescale 1ns/10ps
module video_ctrl_regs_test;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic half_line = 1'b0;
   logic frame_start = 1'b0;
   logic line_start = 1'b0;
   logic phase_sample = 1'b0;
   logic scl, host_sda, sda_out, sda_oe, vblank_end, genlock, osc_zero, z;
   logic [7:0] d;
   logic [7:0] hl_idx = 8'h00;
   logic [7:0] vb_at;
   logic [7:0] cw [5] = '{8'h00, 8'h0a, 8'h0f, 8'h05, 8'h06};
   logic [7:0] ce [5] = '{8'h00, 8'h0a, 8'h0f, 8'h0f, 8'h0e};
   int mismatches = 0;
   int check_count = 0;
   video_regs_pkg::video_std_t std = video_regs_pkg::STD_NTSC;
   video_regs_pkg::video_status_t status = {10'b0110000000, 16'h0000};
   video_regs_pkg::video_ctrl_t ctrl;
   // Pull-up on the shared data line
   wire sda_line = host_sda & ~(sda_oe & ~sda_out);
   always #2 clk = ~clk;
   always @(posedge clk) if (frame_start) vb_at <= 8'h00;
      else if (vblank_end === 1'b1) vb_at <= hl_idx;
   video_ctrl_regs #(.FILTER_CYCLES(2)) u_video_ctrl_regs (.MCLK_I(clk), .NRST_I(nrst), .SCL_I(scl),
      .SDA_I(sda_line), .SDA_O(sda_out), .SDA_OE_O(sda_oe), .HALF_LINE_I(half_line), .FRAME_START_I(frame_start),
      .LINE_START_I(line_start), .PHASE_SAMPLE_I(phase_sample), .STD_I(std), .STATUS_I(status), .CTRL_O(ctrl),
      .VBLANK_END_O(vblank_end), .GENLOCK_PHASE_RESET_O(genlock), .OSC_PHASE_ZERO_O(osc_zero));
   host_port_model u_host_port_model (.clk_i(clk), .sda_i(sda_line), .scl_o(scl), .sda_o(host_sda));
   // ------------------------------
   // Tasks
   // ------------------------------
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      u_host_port_model.write_reg(a, v);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      u_host_port_model.read_reg(a, d);
      chk8(d, e);
   endtask
   task automatic line_pulse();
      @(posedge clk);
      line_start <= 1'b1;
      @(posedge clk);
      line_start <= 1'b0;
      #1 z = osc_zero;
      @(posedge clk);
   endtask
   // Steps 63 half lines from frame start and checks the half line index of the blank end pulse
   task automatic vb(input video_regs_pkg::video_std_t s, input logic [7:0] off, input logic [7:0] e);
      wr(8'h19, off);
      std <= s;
      frame_start <= 1'b1;
      @(posedge clk);
      frame_start <= 1'b0;
      for (int i = 1; i < 64; i++) begin
         @(posedge clk);
         hl_idx <= 8'(i);
         half_line <= 1'b1;
         @(posedge clk);
         half_line <= 1'b0;
         @(posedge clk);
      end
      chk8(vb_at, e);
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      repeat (90000) @(posedge clk);
      mismatches++;
      results();
   end
   initial begin
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      repeat (4) @(posedge clk);
      chk8({1'b0, ctrl}, 8'h01);
      rd(8'h19, 8'h00);
      rd(8'h1a, 8'h00);
      rd(8'h20, 8'h04);
      wr(8'h80, 8'h00);
      rd(8'h80, video_regs_pkg::DEF_REVISION);
      for (int i = 0; i < 3; i++) begin
         wr(8'h20, 8'h01 << i);
         rd(8'h20, 8'h01 << i);
         chk8({1'b0, ctrl}, 8'h04 >> i);
      end
      for (int i = 0; i < 5; i++) begin
         wr(8'h1a, cw[i]);
         rd(8'h1a, ce[i]);
         chk8({4'h0, ctrl[6:3]}, ce[i]);
      end
      status <= {10'b1110101011, 8'h9c, 8'h5a};
      @(posedge clk);
      phase_sample <= 1'b1;
      @(posedge clk);
      phase_sample <= 1'b0;
      rd(8'h81, 8'ha7);
      rd(8'h82, 8'h30);
      rd(8'h83, 8'h9c);
      rd(8'h84, 8'h5a);
      status <= {10'b0111010100, 8'h63, 8'h11};
      wr(8'h84, 8'h00);
      rd(8'h81, 8'h4e);
      rd(8'h82, 8'h28);
      rd(8'h84, 8'h5a);
      status <= {10'b0011010100, 8'h63, 8'h11};
      repeat (3) @(posedge clk);
      status <= {10'b0111010100, 8'h63, 8'h11};
      wr(8'h81, 8'h00);
      rd(8'h81, 8'h5e);
      rd(8'h81, 8'h4e);
      wr(8'h1a, 8'h13);
      chk8({6'h00, genlock, osc_zero}, 8'h00);
      rd(8'h1a, 8'h13);
      line_pulse();
      chk8({6'h00, genlock, z}, 8'h02);
      line_pulse();
      chk8({6'h00, genlock, z}, 8'h01);
      rd(8'h1a, 8'h03);
      vb(video_regs_pkg::STD_NTSC, 8'h00, 8'd40);
      vb(video_regs_pkg::STD_NTSC, 8'h03, 8'd46);
      vb(video_regs_pkg::STD_NTSC, 8'hff, 8'd38);
      vb(video_regs_pkg::STD_PAL, 8'hfe, 8'd41);
      chk8(u_host_port_model.nack_cnt[7:0], 8'h00);
      results();
   end
endmodule
